// ### src/bit_decider.sv
// one approximation bit: trial set, then keep or clear on comparator verdict
// assumes select pulses come from the sequencer on the same clock
`timescale 1ns/1ns
module bit_decider (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // control
    input  wire logic clear,
    input  wire logic trial,
    input  wire logic decide,
    input  wire logic comp_high,
    // state
    output logic      bit_q
);
    logic bit_ff;
    logic nxt_bit;

    // clear wins, then trial set, then decision
    assign nxt_bit = clear  ? 1'b0 :
                     trial  ? 1'b1 :
                     decide ? comp_high : bit_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            bit_ff <= 1'b0;
        end else begin
            bit_ff <= nxt_bit;
        end
    end

    assign bit_q = bit_ff;
endmodule

// ### src/pin_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes the source holds each level for at least two clocks
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage read only by the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ### src/sar_adc_pkg.sv
// package for the successive-approximation converter sequencer
// assumes one 100 MHz clock and an external analog front end
package sar_adc_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned RES_BITS     = 12;
    localparam int unsigned NUM_CHANNELS = 16;
    localparam int unsigned CHAN_BITS    = 4;
    localparam int unsigned MSB_INDEX    = 11;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SAMPLE_TIME_NS  = 100;
    localparam int unsigned SAMPLE_CYCLES   =
        (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_CNT_BITS = 8;
    // tap settle plus two synchroniser stages: four cycles per bit
    localparam int unsigned         SETTLE_W    = 2;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = 2'h3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [RES_BITS-1:0]  RESULT_RESET  = 12'h000;
    localparam logic [RES_BITS-1:0]  APPROX_RESET  = 12'h000;
    localparam logic [CHAN_BITS-1:0] CHANNEL_RESET = 4'h0;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_DONE
    } seq_state_t;
endpackage

// ### src/sar_adc_sequencer.sv
// successive-approximation sequencer for a 16-channel 12-bit converter
// assumes an analog sample-and-hold, tap array and comparator outside;
// the comparator answer is asynchronous and is synchronised here
`timescale 1ns/1ns

// Contract
// RL1: pick one of 16 input channels; other pins stay free for port use
// RL2: first compare against half reference; top bit kept if input higher
// RL3: after top bit, set bit 10 as trial and compare automatically
// RL4: second tap chosen by decided bit 11: quarter or three quarters
// RL5: bit 10 stays 1 if input at or above tap, else cleared
// RL6: repeat trial and decide down to bit 0
// RL7: 12-bit approximation register filled MSB first, one bit per step
// RL8: after LSB, copy approximation into result register, held for reading
// RL9: done interrupt raised only after all requested conversions finish
// RL10: hold stays closed for the whole approximation sequence
// RL11: one bit decided per conversion step after sampling
module sar_adc_sequencer
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // conversion request from the host logic
    input  wire logic                 start,
    input  wire logic [CHAN_BITS-1:0] channel_sel,
    input  wire logic [3:0]           conv_count,
    // analog front end
    input  wire logic                 comp_high_async,
    output logic [NUM_CHANNELS-1:0]   analog_input_pins,
    output logic                      sample_en,
    output logic                      hold_en,
    output logic [RES_BITS-1:0]       tap_code,
    // results
    output logic [RES_BITS-1:0]       conversion_result_reg,
    output logic [RES_BITS-1:0]       successive_approx_reg,
    output logic                      result_valid,
    output logic                      conversion_done_irq,
    output logic                      busy
);
    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    seq_state_t                 state_ff;
    seq_state_t                 nxt_state;
    logic [SAMPLE_CNT_BITS-1:0] sample_cnt_ff;
    logic [SAMPLE_CNT_BITS-1:0] nxt_sample_cnt;
    logic [3:0]                 bit_idx_ff;
    logic [3:0]                 nxt_bit_idx;
    logic [3:0]                 remain_ff;
    logic [3:0]                 nxt_remain;
    logic [CHAN_BITS-1:0]       chan_ff;
    logic [NUM_CHANNELS-1:0]    pins_ff;
    logic [RES_BITS-1:0]        result_ff;
    logic                       valid_ff;
    logic                       irq_ff;
    logic                       sample_ff;
    logic                       hold_ff;
    logic                       busy_ff;
    logic                       done_now;
    logic                       conv_clear;
    logic [CHAN_BITS-1:0]       sel_chan;
    logic [NUM_CHANNELS-1:0]    nxt_pins;
    logic                       nxt_sample;
    logic                       nxt_hold;
    logic                       nxt_busy;
    logic [RES_BITS-1:0]        tap_ff;
    logic                       comp_high;
    logic [RES_BITS-1:0]        approx;

    // ----------------------------------------------------------------
    // comparator input crossing
    // ----------------------------------------------------------------
    pin_sync #(.WIDTH(1)) u_comp_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (comp_high_async),
        .sync_out (comp_high)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // schedule of one conversion:
    //   sample   SAMPLE_CYCLES cycles with the selected channel tracked
    //   convert  four cycles per bit, MSB first: trial edge, tap edge,
    //            two synchroniser edges, then the decide edge, which also
    //            sets the next lower trial
    //   done     one cycle; result and pulses follow on its edge
    // a start outside idle is dropped with no indication to the host
    // a decision waits two settle cycles plus two sync cycles per bit
    logic                   start_take;
    logic                   sample_over;
    logic                   step_ready;
    logic                   last_bit;
    logic                   more_convs;
    logic [RES_BITS-1:0]    trial_sel;
    logic [RES_BITS-1:0]    decide_sel;
    logic [SETTLE_W-1:0]    settle_ff;

    assign start_take  = (state_ff == ST_IDLE) && start;
    assign sample_over = (state_ff == ST_SAMPLE) &&
                         (sample_cnt_ff == SAMPLE_CNT_BITS'(SAMPLE_CYCLES - 1));
    assign step_ready  = (state_ff == ST_CONVERT) && (settle_ff == SETTLE_LAST);
    assign last_bit    = (bit_idx_ff == 4'h0);                         // RL6
    assign more_convs  = (remain_ff != 4'h0);
    assign done_now    = (state_ff == ST_DONE);

    // every conversion, first or repeated, starts from an empty word so the
    // first tap is half scale; stale low bits would skew each trial tap
    assign conv_clear  = start_take || (done_now && more_convs);       // RL2

    // the pick comes from the request pins in the accepting cycle, so the
    // one-hot select is up in the same cycle as the sample switch
    assign sel_chan    = start_take ? channel_sel : chan_ff;           // RL1
    assign nxt_pins    = (nxt_state == ST_IDLE) ? '0 :
                         (NUM_CHANNELS'(1) << sel_chan);               // RL1

    // hold closes on the edge that sets the top trial; the tap word shows
    // that trial one cycle later, before the synchroniser samples it
    assign nxt_sample  = (nxt_state == ST_SAMPLE) && !sample_over;
    assign nxt_hold    = (nxt_state == ST_CONVERT);                    // RL10
    assign nxt_busy    = (nxt_state != ST_IDLE);

    // trial on bit MSB at sample end, on bit k-1 when bit k decided
    // trial of the next lower bit follows decision without software  // RL3
    genvar gi;
    generate
        for (gi = 0; gi < RES_BITS; gi++) begin : g_bits
            assign decide_sel[gi] = step_ready && (bit_idx_ff == 4'(gi));  // RL11
            if (gi == MSB_INDEX) begin : g_top
                assign trial_sel[gi] = sample_over;                    // RL2
            end else begin : g_low
                assign trial_sel[gi] = step_ready &&
                                       (bit_idx_ff == 4'(gi + 1));     // RL3
            end
            bit_decider u_bit (
                .mclk      (mclk),
                .reset     (reset),
                .clear     (conv_clear),
                .trial     (trial_sel[gi]),
                .decide    (decide_sel[gi]),
                .comp_high (comp_high),                                // RL5
                .bit_q     (approx[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state      = state_ff;
        nxt_sample_cnt = sample_cnt_ff;
        nxt_bit_idx    = bit_idx_ff;
        nxt_remain     = remain_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state      = ST_SAMPLE;
                    nxt_sample_cnt = '0;
                    nxt_remain     = conv_count;
                end
            end
            ST_SAMPLE: begin
                nxt_sample_cnt = sample_cnt_ff + 1'b1;
                if (sample_over) begin
                    nxt_state   = ST_CONVERT;
                    nxt_bit_idx = 4'(MSB_INDEX);                       // RL7
                end
            end
            ST_CONVERT: begin
                if (step_ready) begin
                    if (last_bit) begin
                        nxt_state = ST_DONE;                           // RL8
                    end else begin
                        nxt_bit_idx = bit_idx_ff - 1'b1;               // RL6
                    end
                end
            end
            ST_DONE: begin
                // further requested conversions resample the same channel
                if (more_convs) begin
                    nxt_state      = ST_SAMPLE;
                    nxt_sample_cnt = '0;
                    nxt_remain     = remain_ff - 1'b1;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff      <= ST_IDLE;
            sample_cnt_ff <= '0;
            bit_idx_ff    <= 4'h0;
            remain_ff     <= 4'h0;
        end else begin
            state_ff      <= nxt_state;
            sample_cnt_ff <= nxt_sample_cnt;
            bit_idx_ff    <= nxt_bit_idx;
            remain_ff     <= nxt_remain;
        end
    end

    // settle counter restarts with each trial so the tap can settle
    always_ff @(posedge mclk) begin
        if (reset || state_ff != ST_CONVERT || step_ready) begin
            settle_ff <= '0;
        end else begin
            settle_ff <= settle_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // channel and pin routing
    // ----------------------------------------------------------------
    // channel latched at start so a mid-conversion change cannot corrupt it
    always_ff @(posedge mclk) begin
        if (reset) begin
            chan_ff <= CHANNEL_RESET;
            pins_ff <= '0;
        end else begin
            if (start_take) begin
                chan_ff <= channel_sel;                                // RL1
            end
            pins_ff <= nxt_pins;                                       // RL1
        end
    end

    // ----------------------------------------------------------------
    // sample and hold control, tap code
    // ----------------------------------------------------------------
    // tap word is the approximation so far; trial bit set gives the
    // midpoint of the remaining span (half, then quarter or 3/4)
    always_ff @(posedge mclk) begin
        if (reset) begin
            sample_ff <= 1'b0;
            hold_ff   <= 1'b0;
            tap_ff    <= APPROX_RESET;
            busy_ff   <= 1'b0;
        end else begin
            sample_ff <= nxt_sample;
            hold_ff   <= nxt_hold;                                     // RL10
            tap_ff    <= approx;                                       // RL4
            busy_ff   <= nxt_busy;
        end
    end

    // ----------------------------------------------------------------
    // result and interrupt
    // ----------------------------------------------------------------
    // result copied on the done edge, before the word is cleared for a repeat
    always_ff @(posedge mclk) begin
        if (reset) begin
            result_ff <= RESULT_RESET;
            valid_ff  <= 1'b0;
            irq_ff    <= 1'b0;
        end else begin
            valid_ff <= done_now;
            irq_ff   <= done_now && !more_convs;                       // RL9
            if (done_now) begin
                result_ff <= approx;                                   // RL8
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign analog_input_pins     = pins_ff;
    assign sample_en             = sample_ff;
    assign hold_en               = hold_ff;
    assign tap_code              = tap_ff;
    assign conversion_result_reg = result_ff;
    assign successive_approx_reg = tap_ff;
    assign result_valid          = valid_ff;
    assign conversion_done_irq   = irq_ff;
    assign busy                  = busy_ff;
endmodule

// ### testbench/sar_adc_sequencer_bench.sv
// self-checking bench for the converter sequencer with analog model
// assumes the model's comparator makes the result equal the input code
`timescale 1ns/1ns
module sar_adc_sequencer_bench
    import sar_adc_pkg::*;
;
    // ------------------------------------------------------------
    // signals, design and front end
    // ------------------------------------------------------------
    typedef struct packed {logic [3:0] ch; logic [3:0] cnt; logic [11:0] val;} row_t;
    logic                                  mclk;
    logic                                  reset;
    logic                                  start;
    logic [CHAN_BITS-1:0]                  channel_sel;
    logic [3:0]                            conv_count;
    logic                                  comp_high_async;
    logic [NUM_CHANNELS-1:0]               analog_input_pins;
    logic                                  sample_en;
    logic                                  hold_en;
    logic [RES_BITS-1:0]                   tap_code;
    logic [RES_BITS-1:0]                   sar_q;
    logic [RES_BITS-1:0]                   conversion_result_reg;
    logic                                  result_valid;
    logic                                  conversion_done_irq;
    logic                                  busy;
    logic [NUM_CHANNELS-1:0][RES_BITS-1:0] vin;
    int                                    fail_count = 0;
    int                                    cmp_count = 0;
    // edges of the tap tree: half, quarters, exact quarter, extremes
    row_t rows [8] = '{'{4'h0, 4'h0, 12'h000}, '{4'hF, 4'h0, 12'hFFF},
        '{4'h5, 4'h0, 12'h800}, '{4'hA, 4'h0, 12'h7FF}, '{4'h3, 4'h0, 12'hBFF},
        '{4'hC, 4'h0, 12'h400}, '{4'h7, 4'h2, 12'h555}, '{4'h9, 4'hF, 12'hAAA}};

    sar_adc_sequencer dut_u (.mclk(mclk), .reset(reset), .start(start),
        .channel_sel(channel_sel), .conv_count(conv_count),
        .comp_high_async(comp_high_async), .analog_input_pins(analog_input_pins),
        .sample_en(sample_en), .hold_en(hold_en), .tap_code(tap_code),
        .conversion_result_reg(conversion_result_reg), .successive_approx_reg(sar_q),
        .result_valid(result_valid), .conversion_done_irq(conversion_done_irq),
        .busy(busy));
    sar_front_end_model fe_u (.mclk(mclk), .analog_input_pins(analog_input_pins),
        .sample_en(sample_en), .hold_en(hold_en), .tap_code(tap_code), .vin(vin),
        .comp_high(comp_high_async));

    always #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // one run; other channels carry the inverse so a wrong pick shows
    task automatic conv(input row_t r, input bit poke);
        int n;
        @(posedge mclk);
        for (int i = 0; i < 16; i++) vin[i] <= (i == r.ch) ? r.val : ~r.val;
        start <= 1'b1;
        channel_sel <= r.ch;
        conv_count <= r.cnt;
        @(posedge mclk);
        start <= 1'b0;
        #1 chk("pins", analog_input_pins, 16'h0001 << r.ch);
        if (poke) begin
            repeat (20) @(posedge mclk);
            start <= 1'b1;
            channel_sel <= r.ch + 4'h1;
            @(posedge mclk);
            start <= 1'b0;
        end
        for (int k = 0; k <= r.cnt; k++) begin
            n = 0;
            while (result_valid !== 1'b1 && n < 200) begin
                @(posedge mclk);
                #1;
                n++;
            end
            chk("valid", result_valid, 1);
            chk("result", conversion_result_reg, r.val + 12'(k));
            chk("sar", sar_q, r.val + 12'(k));
            chk("irq", conversion_done_irq, k == r.cnt);
            // each repeat sees a new level, so stale low bits would show
            @(posedge mclk);
            vin[r.ch] <= r.val + 12'(k + 1);
            #1;
        end
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        repeat (3) @(posedge mclk);
        #1 chk("busy", busy, 0);
    endtask

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        start = 1'b0;
        channel_sel = 4'h0;
        conv_count = 4'h0;
        vin = '0;
        repeat (4) @(posedge mclk);
        #1 chk("busy", busy, 0);
        chk("pins", analog_input_pins, 0);
        chk("result", conversion_result_reg, RESULT_RESET);
        @(posedge mclk);
        reset <= 1'b0;
        foreach (rows[i]) conv(rows[i], 1'b0);
        conv(row_t'{4'h6, 4'h0, 12'h123}, 1'b1);
        // reset in mid-conversion must drop everything
        @(posedge mclk);
        start <= 1'b1;
        channel_sel <= 4'h2;
        @(posedge mclk);
        start <= 1'b0;
        repeat (30) @(posedge mclk);
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("busy", busy, 0);
        chk("hold", hold_en, 0);
        chk("result", conversion_result_reg, RESULT_RESET);
        @(posedge mclk);
        reset <= 1'b0;
        conv(rows[1], 1'b0);
        finish_test();
    end

    // cut a hang well past the expected run of about 1700 cycles
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule

// ### testbench/sar_adc_sequencer_chk.sv
// checker for the converter sequencer, sees only the top-level ports
// assumes one mclk domain with synchronous active-high reset
`timescale 1ns/1ns
module sar_adc_sequencer_chk
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // front end
    input  wire logic [NUM_CHANNELS-1:0] analog_input_pins,
    input  wire logic                    sample_en,
    input  wire logic                    hold_en,
    input  wire logic [RES_BITS-1:0]     tap_code,
    // results
    input  wire logic [RES_BITS-1:0]     conversion_result_reg,
    input  wire logic                    result_valid,
    input  wire logic                    conversion_done_irq
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_pin_onehot; sample_en |-> $onehot(analog_input_pins); endproperty
    a_pin_onehot: assert property (p_pin_onehot) else $error("select not one-hot");
    // tap word follows the closing hold by one cycle
    property p_first_tap; $rose(hold_en) |=> tap_code == 12'h800; endproperty
    a_first_tap: assert property (p_first_tap) else $error("first tap wrong");
    property p_second_tap;
        $rose(hold_en) |-> ##[1:8] (tap_code == 12'hC00 || tap_code == 12'h400);
    endproperty
    a_second_tap: assert property (p_second_tap) else $error("second tap wrong");
    property p_no_overlap; !(sample_en && hold_en); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("sample during hold");
    property p_hold_keep; $rose(hold_en) |-> hold_en[*8]; endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold opened early");
    property p_finish_time; $rose(hold_en) |-> ##[44:56] result_valid; endproperty
    a_finish_time: assert property (p_finish_time) else $error("result late");
    property p_valid_pulse; result_valid |=> !result_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_result_hold; !result_valid |-> $stable(conversion_result_reg); endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");
    property p_irq_last; conversion_done_irq |-> result_valid; endproperty
    a_irq_last: assert property (p_irq_last) else $error("irq without result");

    // main scenarios reached
    c_irq: cover property (conversion_done_irq);
    c_mid_result: cover property (result_valid && !conversion_done_irq);
    c_hold: cover property ($rose(hold_en));
endmodule

bind sar_adc_sequencer sar_adc_sequencer_chk chk_u (.mclk, .reset, .analog_input_pins,
    .sample_en, .hold_en, .tap_code, .conversion_result_reg, .result_valid,
    .conversion_done_irq);

// ### testbench/sar_front_end_model.sv
// behavioural analog front end: sample-and-hold, tap array, comparator
// assumes the tap array turns the code word into its midpoint voltage
`timescale 1ns/1ns
module sar_front_end_model
    import sar_adc_pkg::*;
(
    // clock
    input  wire logic                                  mclk,
    // select and phase
    input  wire logic [NUM_CHANNELS-1:0]               analog_input_pins,
    input  wire logic                                  sample_en,
    input  wire logic                                  hold_en,
    input  wire logic [RES_BITS-1:0]                   tap_code,
    // input levels given as ideal codes
    input  wire logic [NUM_CHANNELS-1:0][RES_BITS-1:0] vin,
    // comparator
    output logic                                       comp_high
);
    // ------------------------------------------------------------
    // hold and compare
    // ------------------------------------------------------------
    logic [RES_BITS-1:0] sel_v;
    logic [RES_BITS-1:0] held_ff;
    logic                wander_ff = 1'b0;

    // mux of the selected pin; nothing selected reads as zero
    always_comb begin
        sel_v = '0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (analog_input_pins[i]) begin
                sel_v = vin[i];
            end
        end
    end

    // track while sampling, frozen while the hold is closed
    always_ff @(posedge mclk) begin
        if (sample_en) begin
            held_ff <= sel_v;
        end
        wander_ff <= ~wander_ff;
    end

    // outside hold the output wanders, so an early decision shows up
    assign comp_high = hold_en ? (held_ff >= tap_code) : wander_ff;
endmodule
